// >>> include/org_pkg.sv
// Constants and types shared by the output register gearbox
package org_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ORG_CTRL_OFS = 12'h000;
    localparam logic [11:0] ORG_STAT_OFS = 12'h004;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int ORG_MODE_LSB = 0;
    localparam int ORG_MODE_W = 3;
    localparam int ORG_LATCH_BIT = 3;
    localparam int ORG_INIT_BIT = 4;
    localparam int ORG_RUN_BIT = 5;
    localparam int ORG_EDGE_LSB = 6;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic ORG_LATCH_RST = 1'b0;
    localparam logic ORG_INIT_RST = 1'b0;
    localparam logic ORG_RUN_RST = 1'b0;
    // ------------------------------------------------------------
    // Edge placement of the instance
    // ------------------------------------------------------------
    localparam logic [1:0] ORG_EDGE_SIDE = 2'h0;
    localparam logic [1:0] ORG_EDGE_TOP = 2'h1;
    localparam logic [1:0] ORG_EDGE_BOTTOM = 2'h2;
    // ------------------------------------------------------------
    // Operating modes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ORG_MODE_SDR = 3'b001,
        ORG_MODE_DDR = 3'b010,
        ORG_MODE_GEAR = 3'b100
    } org_mode_t;
endpackage

// >>> src/org_gearbox.sv
// Output register block of an I/O cell with SDR, DDR and gearbox paths
`timescale 1ns/1ps
module org_gearbox
    import org_pkg::*;
#(
    parameter logic [1:0] EDGE = ORG_EDGE_SIDE
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic lane_a_pos_data_i,
    input wire logic lane_a_neg_data_i,
    input wire logic lane_b_pos_data_i,
    input wire logic lane_b_neg_data_i,
    input wire logic latch_gate_i,
    input wire logic edge_strobe_clk_first_i,
    input wire logic edge_strobe_clk_second_i,
    output logic io_cell_data_o
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    org_mode_t mode_r;
    logic latch_r;
    logic init_r;
    logic run_r;
    logic phase_r;
    logic [31:0] prdata_r;
    logic [31:0] ctrl_rd;
    logic wr_ctrl;
    logic mode_ok;
    logic mapped;
    org_mode_t wr_mode;

    assign wr_mode = org_mode_t'(pwdata_i[ORG_MODE_LSB +: ORG_MODE_W]);

    always_comb begin
        if (EDGE == ORG_EDGE_BOTTOM) begin
            mode_ok = (wr_mode == ORG_MODE_SDR);
        end else if (EDGE == ORG_EDGE_TOP) begin
            mode_ok = (wr_mode == ORG_MODE_SDR) || (wr_mode == ORG_MODE_DDR);
        end else begin
            mode_ok = (wr_mode == ORG_MODE_SDR) || (wr_mode == ORG_MODE_DDR) || (wr_mode == ORG_MODE_GEAR);
        end
    end

    always_comb begin
        if (paddr_i == ORG_CTRL_OFS) begin
            mapped = 1'b1;
        end else if (paddr_i == ORG_STAT_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign wr_ctrl = psel_i && penable_i && pwrite_i && (paddr_i == ORG_CTRL_OFS);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_r;

    // Mode, latch and init only change while stopped; run bit always writable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= ORG_MODE_SDR;
            latch_r <= ORG_LATCH_RST;
            init_r <= ORG_INIT_RST;
            run_r <= ORG_RUN_RST;
        end else if (wr_ctrl) begin
            run_r <= pwdata_i[ORG_RUN_BIT];
            if (!run_r && mode_ok) begin
                mode_r <= wr_mode;
                latch_r <= pwdata_i[ORG_LATCH_BIT];
                init_r <= pwdata_i[ORG_INIT_BIT];
            end
        end
    end

    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[ORG_MODE_LSB +: ORG_MODE_W] = mode_r;
        ctrl_rd[ORG_LATCH_BIT] = latch_r;
        ctrl_rd[ORG_INIT_BIT] = init_r;
        ctrl_rd[ORG_RUN_BIT] = run_r;
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            if (paddr_i == ORG_CTRL_OFS) begin
                prdata_r <= ctrl_rd;
            end else if (paddr_i == ORG_STAT_OFS) begin
                prdata_r <= {24'h00_0000, EDGE, io_cell_data_o, phase_r, run_r, mode_r};
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Capture stage
    // ------------------------------------------------------------
    logic a_pos_r;
    logic a_neg_r;
    logic b_pos_r;
    logic b_neg_r;
    logic a_neg_lat_r;
    logic b_pos_lat_r;
    logic b_neg_lat_r;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            a_pos_r <= 1'b0;
            a_neg_r <= 1'b0;
            b_pos_r <= 1'b0;
            b_neg_r <= 1'b0;
        end else begin
            a_pos_r <= lane_a_pos_data_i;
            a_neg_r <= lane_a_neg_data_i;
            b_pos_r <= lane_b_pos_data_i;
            b_neg_r <= lane_b_neg_data_i;
        end
    end

    // Second stage delays three values a cycle, as the latch does
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            a_neg_lat_r <= 1'b0;
            b_pos_lat_r <= 1'b0;
            b_neg_lat_r <= 1'b0;
        end else begin
            a_neg_lat_r <= a_neg_r;
            b_pos_lat_r <= b_pos_r;
            b_neg_lat_r <= b_neg_r;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_r <= 1'b0;
        end else if (run_r && mode_r == ORG_MODE_DDR) begin
            phase_r <= !phase_r;
        end else begin
            phase_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output element
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            io_cell_data_o <= ORG_INIT_RST;
        end else if (!run_r) begin
            io_cell_data_o <= init_r;
        end else begin
            case (mode_r)
                ORG_MODE_SDR: begin
                    if (!latch_r || latch_gate_i) begin
                        io_cell_data_o <= lane_a_pos_data_i;
                    end
                end
                ORG_MODE_DDR: begin
                    io_cell_data_o <= phase_r ? a_neg_lat_r : a_pos_r;
                end
                ORG_MODE_GEAR: begin
                    case ({edge_strobe_clk_first_i, edge_strobe_clk_second_i})
                        2'b00: io_cell_data_o <= a_pos_r;
                        2'b01: io_cell_data_o <= a_neg_r;
                        2'b10: io_cell_data_o <= b_pos_lat_r;
                        default: io_cell_data_o <= b_neg_lat_r;
                    endcase
                end
                default: io_cell_data_o <= init_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_cfg_static: assert property (run_r && $past(run_r) |-> $stable(mode_r) && $stable(latch_r))
        else $error("mode changed while running");
    a_init_hold: assert property (!run_r |=> io_cell_data_o == $past(init_r))
        else $error("stopped output not at init value");
    a_sdr_flop: assert property (run_r && mode_r == ORG_MODE_SDR && !latch_r
        |=> io_cell_data_o == $past(lane_a_pos_data_i))
        else $error("sdr flop output wrong");
    a_sdr_latch: assert property (run_r && mode_r == ORG_MODE_SDR && latch_r && !latch_gate_i
        |=> $stable(io_cell_data_o))
        else $error("closed latch changed");
    a_ddr_delay: assert property (1'b1 |=> ##1 a_neg_lat_r == $past(lane_a_neg_data_i, 2))
        else $error("ddr latch stage wrong");
    a_ddr_alternate: assert property (run_r && mode_r == ORG_MODE_DDR && $past(run_r)
        |=> phase_r != $past(phase_r))
        else $error("ddr phase did not toggle");
    a_gear_select: assert property (run_r && mode_r == ORG_MODE_GEAR
        && edge_strobe_clk_first_i && edge_strobe_clk_second_i |=> io_cell_data_o == $past(b_neg_r, 2))
        else $error("gearbox lane b neg select wrong");
    a_gear_capture: assert property (1'b1 |=> ##1 b_pos_lat_r == $past(lane_b_pos_data_i, 2))
        else $error("gearbox lane b capture wrong");
    a_edge_top: assert property (EDGE == ORG_EDGE_TOP |-> mode_r != ORG_MODE_GEAR)
        else $error("top edge in gearbox mode");
    a_edge_bottom: assert property (EDGE == ORG_EDGE_BOTTOM |-> mode_r == ORG_MODE_SDR)
        else $error("bottom edge not in sdr mode");

    c_sdr_run: cover property (run_r && mode_r == ORG_MODE_SDR ##1 run_r);
    c_ddr_run: cover property (run_r && mode_r == ORG_MODE_DDR ##1 run_r ##1 run_r);
    c_gear_run: cover property (run_r && mode_r == ORG_MODE_GEAR && edge_strobe_clk_first_i);
    c_refused_wr: cover property (wr_ctrl && run_r);
endmodule // org_gearbox

// >>> tb/org_pad_model.sv
// Output buffer model driving the pin
`timescale 1ns/1ps
module org_pad_model (
    input wire logic data_i,
    output logic pad_o
);
    // Buffer follows the registered data, never the core
    assign pad_o = data_i;
endmodule // org_pad_model

// >>> tb/org_gearbox_tb_top.sv
// Self-checking bench of the output register gearbox
`timescale 1ns/1ps
module org_gearbox_tb_top;
    import org_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic [31:0] prdata_top;
    logic [31:0] prdata_bot;
    logic pready_o, pslverr_o, io_cell_data_o, pad;
    logic a_p = 1'b0, a_n = 1'b0, b_p = 1'b0, b_n = 1'b0, gate = 1'b0, sf = 1'b0, ss = 1'b0;
    logic [7:0] lfsr_r = 8'h46;
    logic [32:0] rq[$];
    logic pq[$];
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    org_gearbox dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .lane_a_pos_data_i(a_p), .lane_a_neg_data_i(a_n),
        .lane_b_pos_data_i(b_p), .lane_b_neg_data_i(b_n), .latch_gate_i(gate),
        .edge_strobe_clk_first_i(sf), .edge_strobe_clk_second_i(ss), .io_cell_data_o(io_cell_data_o));
    // Top and bottom edge copies share every input, only their read data is checked
    org_gearbox #(.EDGE(ORG_EDGE_TOP)) dut_top_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_top), .pready_o(), .pslverr_o(), .lane_a_pos_data_i(a_p), .lane_a_neg_data_i(a_n),
        .lane_b_pos_data_i(b_p), .lane_b_neg_data_i(b_n), .latch_gate_i(gate),
        .edge_strobe_clk_first_i(sf), .edge_strobe_clk_second_i(ss), .io_cell_data_o());
    org_gearbox #(.EDGE(ORG_EDGE_BOTTOM)) dut_bot_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_bot), .pready_o(), .pslverr_o(), .lane_a_pos_data_i(a_p), .lane_a_neg_data_i(a_n),
        .lane_b_pos_data_i(b_p), .lane_b_neg_data_i(b_n), .latch_gate_i(gate),
        .edge_strobe_clk_first_i(sf), .edge_strobe_clk_second_i(ss), .io_cell_data_o());
    org_pad_model pad_u (.data_i(io_cell_data_o), .pad_o(pad));
    always #20 clk_i = ~clk_i;
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk_i);
        if (!w) rq.push_back(e);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Each cycle notes the pin value due one edge later
    task automatic stream(input logic lat);
        logic v, g, ex;
        ex = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            if (i > 0) pq.push_back(ex);
            v = rnd() > 8'h7f;
            g = (i == 0) | rnd() > 8'h7f;
            a_p <= v;
            gate <= g;
            if (!lat || g) ex = v;
        end
        $display("test sdr latch=%0d done", lat);
    endtask
    always @(negedge clk_i) begin
        if (pq.size() > 0) chk("pin", {31'h0, pq.pop_front()}, {31'h0, pad});
    end
    always @(posedge clk_i) begin
        logic [32:0] e;
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && rq.size() > 0) begin
            e = rq.pop_front();
            chk("prdata", e[31:0], prdata_o);
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr_o});
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        int n;
        logic p, l;
        logic [7:0] r;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        pq.push_back(1'b0);
        apb(1'b0, ORG_CTRL_OFS, 32'h0, 33'h1);
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
        $display("test regs done");
        apb(1'b1, ORG_CTRL_OFS, 32'h21, 33'h0);
        stream(1'b0);
        apb(1'b1, ORG_CTRL_OFS, 32'h22, 33'h0);
        apb(1'b0, ORG_CTRL_OFS, 32'h0, 33'h21);
        apb(1'b1, ORG_CTRL_OFS, 32'h0, 33'h0);
        apb(1'b1, ORG_CTRL_OFS, 32'h29, 33'h0);
        stream(1'b1);
        apb(1'b1, ORG_CTRL_OFS, 32'h0, 33'h0);
        a_p <= 1'b1;
        a_n <= 1'b0;
        apb(1'b1, ORG_CTRL_OFS, 32'h22, 33'h0);
        repeat (6) @(negedge clk_i);
        p = pad;
        n = 0;
        repeat (8) begin
            @(negedge clk_i);
            n += (pad !== p);
            p = pad;
        end
        chk("ddr_toggles", 32'd8, n);
        $display("test ddr done");
        apb(1'b1, ORG_CTRL_OFS, 32'h0, 33'h0);
        apb(1'b1, ORG_CTRL_OFS, 32'h24, 33'h0);
        apb(1'b0, ORG_CTRL_OFS, 32'h0, 33'h24);
        chk("top_ctrl", 32'h22, prdata_top);
        chk("bottom_ctrl", 32'h29, prdata_bot);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            r = rnd();
            {a_p, a_n, b_p, b_n} <= r[3:0];
            {sf, ss} <= 2'(i % 4);
            repeat (4) @(posedge clk_i);
            pq.push_back(r[3 - (i % 4)]);
        end
        $display("test gearbox done");
        apb(1'b1, ORG_CTRL_OFS, 32'h0, 33'h0);
        apb(1'b1, ORG_CTRL_OFS, 32'h11, 33'h0);
        repeat (2) @(posedge clk_i);
        pq.push_back(1'b1);
        repeat (2) @(posedge clk_i);
        $display("test init done");
        apb(1'b0, ORG_STAT_OFS, 32'h0, 33'h21);
        // Quiet lanes so in-flight pipeline checks see zeros across reset
        a_p <= 1'b0;
        a_n <= 1'b0;
        b_p <= 1'b0;
        b_n <= 1'b0;
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        pq.push_back(1'b0);
        apb(1'b0, ORG_CTRL_OFS, 32'h0, 33'h1);
        $display("test reset done");
        results();
    end
endmodule // org_gearbox_tb_top
